// *** logic/ubtr_pkg.sv ***
// Purpose: Constants for the branch trace and break request block
// Assumes: AXI4-Lite register access, 32-bit data, 250 MHz core clock
// Notes:   Functional notes below are tagged in the design files
//
// Functional notes
// - Read-only 32-bit trace register holds first fetch address after branch.
// - Destination fetch address sits in bits 27 down to 0.
// - Valid flag in bit 31 set when a destination address is stored.
// - Valid flag clears on a trace register read and on any reset; a read pops the queue, so bit 31 clears only when the last entry is read.
// - Resets leave stored destination addresses untouched.
// - Eight trace entries form a queue shifted by one per branch.
// - Bits 30 to 28 read as zero; software writes only zeros there.
// - Channel A space identifier register, 8-bit read/write, not reset.
// - Channel B space identifier register, 8-bit read/write, not reset.
// - No break while any of three bus-cycle groups is 00.
// - Satisfied break conditions raise a request to the interrupt controller.
// - Break type reported with each break: fetch before, fetch after, data.
// - Matches set separate CPU and DMA flags for channels A and B.
// - Match flags stay set; a software write of 0 or a reset clears them.
// - Near-simultaneous data and fetch breaks give one request, both flags.
// - Trace capture only while trace enable is 1; all branch kinds count.
// - Interrupt branches capture the first handler address.
package ubtr_pkg;

    localparam int          UBTR_ADDR_W      = 28;
    localparam int          UBTR_QDEPTH      = 8;
    localparam int          UBTR_ID_W        = 8;
    localparam int          UBTR_VALID_BIT   = 31;

    localparam logic [7:0]  UBTR_OFF_TRACE   = 8'h00;
    localparam logic [7:0]  UBTR_OFF_ID_A    = 8'h04;
    localparam logic [7:0]  UBTR_OFF_ID_B    = 8'h08;
    localparam logic [7:0]  UBTR_OFF_FLAGS   = 8'h0C;
    localparam logic [7:0]  UBTR_OFF_STATUS  = 8'h10;

    localparam int          UBTR_FLAG_CPU_A  = 0;
    localparam int          UBTR_FLAG_DMA_A  = 1;
    localparam int          UBTR_FLAG_CPU_B  = 2;
    localparam int          UBTR_FLAG_DMA_B  = 3;

    localparam logic [1:0]  UBTR_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  UBTR_RESP_SLVERR = 2'h2;

    localparam logic [3:0]  UBTR_FLAGS_RST   = 4'h0;

    typedef enum logic [1:0] {
        UBTR_BRK_NONE,
        UBTR_BRK_FETCH_BEFORE,
        UBTR_BRK_FETCH_AFTER,
        UBTR_BRK_DATA
    } ubtr_brk_type_t;

endpackage

// *** logic/ubtr_trace_queue.sv ***
// Purpose: Eight-deep shifting queue of branch destination entries
// Assumes: One push and one pop at most per cycle
// Notes:   Head entry is a register and is the read data
`timescale 1ns/10ps
module ubtr_trace_queue
    import ubtr_pkg::*;
#(
    parameter int DEPTH  = UBTR_QDEPTH,
    parameter int ADDR_W = UBTR_ADDR_W
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    input  wire logic              push,
    input  wire logic [ADDR_W-1:0] push_addr,
    input  wire logic              pop,
    output logic                   head_valid,
    output logic [ADDR_W-1:0]      head_addr
);

    logic [ADDR_W-1:0] addr_reg  [DEPTH];
    logic [DEPTH-1:0]  valid_reg;

    assign head_valid = valid_reg[0];
    assign head_addr  = addr_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Valid flags, cleared by reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            valid_reg <= '0;
        else if (clk_en)
        begin
            if (push && pop)
                valid_reg[0] <= 1'b1;
            else if (push)
                valid_reg <= {valid_reg[DEPTH-2:0], 1'b1};
            else if (pop)
                valid_reg <= {1'b0, valid_reg[DEPTH-1:1]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Addresses, never reset
    always_ff @(posedge aclk)
    begin
        if (clk_en)
        begin
            if (push && pop)
                addr_reg[0] <= push_addr;
            else if (push)
            begin
                addr_reg[0] <= push_addr;
                for (int i = 1; i < DEPTH; i++)
                    addr_reg[i] <= addr_reg[i-1];
            end
            else if (pop)
            begin
                for (int i = 0; i < DEPTH - 1; i++)
                    addr_reg[i] <= addr_reg[i+1];
            end
        end
    end

endmodule

// *** logic/ubtr_top.sv ***
// Purpose: Branch destination trace, space id compare and break request
// Assumes: Address/data compare results come from the rest of the unit
// Notes:   Registers reached over AXI4-Lite
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module ubtr_top
    import ubtr_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   clk_en,
    // AXI4-Lite slave
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Branch events from the core
    input  wire logic                   trace_enable,
    input  wire logic                   branch_event,
    input  wire logic                   branch_is_interrupt,
    input  wire logic [UBTR_ADDR_W-1:0] branch_fetch_addr,
    input  wire logic [UBTR_ADDR_W-1:0] handler_fetch_addr,
    // Bus cycle under observation
    input  wire logic                   cyc_valid,
    input  wire logic                   cyc_is_dma,
    input  wire logic                   cyc_is_fetch,
    input  wire logic                   cyc_is_write,
    input  wire logic [UBTR_ID_W-1:0]   cyc_space_id,
    input  wire logic                   cmp_hit_a,
    input  wire logic                   cmp_hit_b,
    input  wire logic [5:0]             bus_cycle_condition_a,
    input  wire logic [5:0]             bus_cycle_condition_b,
    input  wire logic                   pc_break_after_a,
    input  wire logic                   pc_break_after_b,
    // Request to interrupt controller and core
    input  wire logic                   break_ack,
    output logic                        break_request,
    output logic [1:0]                  break_type
);

    logic                   awready_reg;
    logic                   wready_reg;
    logic                   bvalid_reg;
    logic [1:0]             bresp_reg;
    logic                   arready_reg;
    logic                   rvalid_reg;
    logic [1:0]             rresp_reg;
    logic [31:0]            rdata_reg;
    logic                   aw_held_reg;
    logic                   w_held_reg;
    logic [7:0]             awaddr_reg;
    logic [31:0]            wdata_reg;
    logic [3:0]             wstrb_reg;
    logic [UBTR_ID_W-1:0]   space_id_field_a;
    logic [UBTR_ID_W-1:0]   space_id_field_b;
    logic [3:0]             match_flags_reg;
    logic                   break_req_reg;
    ubtr_brk_type_t         break_type_reg;

    logic                   aw_take;
    logic                   w_take;
    logic                   ar_take;
    logic                   wr_do;
    logic                   wr_flags;
    logic                   trace_push;
    logic                   trace_pop;
    logic [UBTR_ADDR_W-1:0] trace_addr;
    logic                   head_valid;
    logic [UBTR_ADDR_W-1:0] head_addr;
    logic                   hit_a;
    logic                   hit_b;
    logic [3:0]             flag_set;

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign break_request = break_req_reg;
    assign break_type    = break_type_reg;

    assign aw_take  = s_axi_awvalid && awready_reg;
    assign w_take   = s_axi_wvalid && wready_reg;
    assign ar_take  = s_axi_arvalid && arready_reg;
    assign wr_do    = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_flags = wr_do && awaddr_reg == UBTR_OFF_FLAGS && wstrb_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Branch trace capture
    assign trace_push = branch_event && trace_enable;
    assign trace_addr = branch_is_interrupt ? handler_fetch_addr
                                            : branch_fetch_addr;
    assign trace_pop  = ar_take && s_axi_araddr == UBTR_OFF_TRACE;

    ubtr_trace_queue #(
        .DEPTH      (UBTR_QDEPTH),
        .ADDR_W     (UBTR_ADDR_W)
    ) u_queue (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .clk_en     (clk_en),
        .push       (trace_push),
        .push_addr  (trace_addr),
        .pop        (trace_pop),
        .head_valid (head_valid),
        .head_addr  (head_addr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write address and data channels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b1;
            aw_held_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
        end
        else if (clk_en)
        begin
            if (aw_take)
            begin
                awready_reg <= 1'b0;
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            else if (wr_do)
            begin
                awready_reg <= 1'b1;
                aw_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready_reg <= 1'b1;
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h00000000;
            wstrb_reg  <= 4'h0;
        end
        else if (clk_en)
        begin
            if (w_take)
            begin
                wready_reg <= 1'b0;
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            else if (wr_do)
            begin
                wready_reg <= 1'b1;
                w_held_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= UBTR_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (wr_do)
            begin
                bvalid_reg <= 1'b1;
                case (awaddr_reg)
                    UBTR_OFF_TRACE,
                    UBTR_OFF_ID_A,
                    UBTR_OFF_ID_B,
                    UBTR_OFF_FLAGS,
                    UBTR_OFF_STATUS: bresp_reg <= UBTR_RESP_OKAY;
                    default:         bresp_reg <= UBTR_RESP_SLVERR;
                endcase
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Space identifier registers, not reset
    always_ff @(posedge aclk)
    begin
        if (clk_en && wr_do && wstrb_reg[0])
        begin
            if (awaddr_reg == UBTR_OFF_ID_A)
                space_id_field_a <= wdata_reg[UBTR_ID_W-1:0];
            if (awaddr_reg == UBTR_OFF_ID_B)
                space_id_field_b <= wdata_reg[UBTR_ID_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel condition match
    function automatic logic group_ok(input logic [5:0] cond,
                                      input logic       is_dma,
                                      input logic       is_fetch,
                                      input logic       is_write);
        logic src;
        logic kind;
        logic dir;
        src  = is_dma   ? cond[5] : cond[4];
        kind = is_fetch ? cond[3] : cond[2];
        dir  = is_write ? cond[1] : cond[0];
        return src && kind && dir;
    endfunction

    assign hit_a = cyc_valid && cmp_hit_a
                && cyc_space_id == space_id_field_a
                && group_ok(bus_cycle_condition_a, cyc_is_dma,
                            cyc_is_fetch, cyc_is_write);
    assign hit_b = cyc_valid && cmp_hit_b
                && cyc_space_id == space_id_field_b
                && group_ok(bus_cycle_condition_b, cyc_is_dma,
                            cyc_is_fetch, cyc_is_write);

    always_comb
    begin
        flag_set                  = 4'h0;
        flag_set[UBTR_FLAG_CPU_A] = hit_a && !cyc_is_dma;
        flag_set[UBTR_FLAG_DMA_A] = hit_a && cyc_is_dma;
        flag_set[UBTR_FLAG_CPU_B] = hit_b && !cyc_is_dma;
        flag_set[UBTR_FLAG_DMA_B] = hit_b && cyc_is_dma;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky match flags, write 0 clears, set wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            match_flags_reg <= UBTR_FLAGS_RST;
        else if (clk_en)
        begin
            if (wr_flags)
                match_flags_reg <= (match_flags_reg & wdata_reg[3:0])
                                 | flag_set;
            else
                match_flags_reg <= match_flags_reg | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break request and type
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            break_req_reg  <= 1'b0;
            break_type_reg <= UBTR_BRK_NONE;
        end
        else if (clk_en)
        begin
            if (break_req_reg)
            begin
                if (break_ack)
                begin
                    break_req_reg  <= 1'b0;
                    break_type_reg <= UBTR_BRK_NONE;
                end
            end
            else if (hit_a || hit_b)
            begin
                break_req_reg <= 1'b1;
                if (!cyc_is_fetch)
                    break_type_reg <= UBTR_BRK_DATA;
                else if (hit_a ? pc_break_after_a : pc_break_after_b)
                    break_type_reg <= UBTR_BRK_FETCH_AFTER;
                else
                    break_type_reg <= UBTR_BRK_FETCH_BEFORE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= UBTR_RESP_OKAY;
            rdata_reg   <= 32'h00000000;
        end
        else if (clk_en)
        begin
            if (ar_take)
            begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rresp_reg   <= UBTR_RESP_OKAY;
                rdata_reg   <= 32'h00000000;
                case (s_axi_araddr)
                    UBTR_OFF_TRACE:
                    begin
                        rdata_reg[UBTR_VALID_BIT] <= head_valid;
                        rdata_reg[UBTR_ADDR_W-1:0] <= head_addr;
                    end
                    UBTR_OFF_ID_A:
                        rdata_reg[UBTR_ID_W-1:0] <= space_id_field_a;
                    UBTR_OFF_ID_B:
                        rdata_reg[UBTR_ID_W-1:0] <= space_id_field_b;
                    UBTR_OFF_FLAGS:
                        rdata_reg[3:0] <= match_flags_reg;
                    UBTR_OFF_STATUS:
                    begin
                        rdata_reg[0]   <= break_req_reg;
                        rdata_reg[2:1] <= break_type_reg;
                    end
                    default:
                        rresp_reg <= UBTR_RESP_SLVERR;
                endcase
            end
            else if (rvalid_reg && s_axi_rready)
            begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

endmodule

// *** tb/ubtr_chk.sv ***
// Purpose: Break request and read path checker
// Assumes: One clock, sync active low reset
// Notes:   Bound to ubtr_top by the bench
`timescale 1ns/10ps
module ubtr_chk
    import ubtr_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    input wire logic        cyc_valid,
    input wire logic        cyc_is_fetch,
    input wire logic [5:0]  bus_cycle_condition_a,
    input wire logic [5:0]  bus_cycle_condition_b,
    input wire logic        break_ack,
    input wire logic        break_request,
    input wire logic [1:0]  break_type,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    logic zero_a;
    logic zero_b;
    assign zero_a = bus_cycle_condition_a[5:4] == 2'h0
        || bus_cycle_condition_a[3:2] == 2'h0
        || bus_cycle_condition_a[1:0] == 2'h0;
    assign zero_b = bus_cycle_condition_b[5:4] == 2'h0
        || bus_cycle_condition_b[3:2] == 2'h0
        || bus_cycle_condition_b[1:0] == 2'h0;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    property p_req_hold;
        break_request && !break_ack && clk_en |=> break_request;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("req dropped");
    property p_req_clear;
        break_request && break_ack && clk_en
            |=> !break_request && break_type == UBTR_BRK_NONE;
    endproperty
    a_req_clear: assert property (p_req_clear)
        else $error("req not cleared");
    property p_type_hold;
        break_request && !break_ack |=> $stable(break_type);
    endproperty
    a_type_hold: assert property (p_type_hold)
        else $error("type changed");
    property p_no_cause;
        !break_request && !cyc_valid && clk_en |=> !break_request;
    endproperty
    a_no_cause: assert property (p_no_cause)
        else $error("req without cycle");
    property p_group_zero;
        !break_request && zero_a && zero_b && clk_en |=> !break_request;
    endproperty
    a_group_zero: assert property (p_group_zero)
        else $error("req with zero group");
    property p_data_type;
        $rose(break_request) && !$past(cyc_is_fetch)
            |-> break_type == UBTR_BRK_DATA;
    endproperty
    a_data_type: assert property (p_data_type)
        else $error("data type");
    property p_fetch_type;
        $rose(break_request) && $past(cyc_is_fetch)
            |-> break_type inside {UBTR_BRK_FETCH_BEFORE,
                                   UBTR_BRK_FETCH_AFTER};
    endproperty
    a_fetch_type: assert property (p_fetch_type)
        else $error("fetch type");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("no answer");
    property p_rsv_zero;
        s_axi_rvalid |-> s_axi_rdata[30:28] == 3'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved bits");
    c_data: cover property (break_request && break_type == UBTR_BRK_DATA);
    c_after: cover property (break_type == UBTR_BRK_FETCH_AFTER);
    c_merge: cover property (break_request && cyc_valid);
endmodule

// *** tb/ubtr_irq_model.sv ***
// Purpose: Interrupt controller model, acks breaks
// Assumes: ack_delay set by the bench
// Notes:   One ack pulse per request
`timescale 1ns/10ps
module ubtr_irq_model
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       break_request,
    input  wire logic [7:0] ack_delay,
    output logic            break_ack
);
    logic [7:0] wait_cnt;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !break_request || break_ack)
        begin
            wait_cnt <= 8'h00;
            break_ack <= 1'b0;
        end
        else if (wait_cnt >= ack_delay)
            break_ack <= 1'b1;
        else
            wait_cnt <= wait_cnt + 8'h01;
    end
endmodule

// *** tb/ubtr_tb.sv ***
// Purpose: Register and break tests
// Assumes: AXI4-Lite master tasks, irq model acks
// Notes:   Times in cycles of a 4 ns clock
`timescale 1ns/10ps
module ubtr_tb
    import ubtr_pkg::*;
;
    logic aclk, aresetn, clk_en, trace_enable, branch_event;
    logic [7:0] s_axi_awaddr, s_axi_araddr, cyc_space_id, ack_delay;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, ex;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, break_type, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, branch_is_interrupt;
    logic [UBTR_ADDR_W-1:0] branch_fetch_addr, handler_fetch_addr;
    logic cyc_valid, cyc_is_dma, cyc_is_fetch, cyc_is_write;
    logic cmp_hit_a, cmp_hit_b, pc_break_after_a, pc_break_after_b;
    logic [5:0] bus_cycle_condition_a, bus_cycle_condition_b;
    logic break_ack, break_request;
    int fails = 0, tests_run = 0, cycles = 0;
    ubtr_top dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trace_enable,
        .branch_event, .branch_is_interrupt, .branch_fetch_addr,
        .handler_fetch_addr, .cyc_valid, .cyc_is_dma, .cyc_is_fetch,
        .cyc_is_write, .cyc_space_id, .cmp_hit_a, .cmp_hit_b,
        .bus_cycle_condition_a, .bus_cycle_condition_b, .pc_break_after_a,
        .pc_break_after_b, .break_ack, .break_request, .break_type);
    ubtr_irq_model irq (.aclk, .aresetn, .break_request, .ack_delay,
        .break_ack);
    ////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", n, exp, seen);
            fails++;
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                check("bresp", 32'(s_axi_bresp), 32'(er));
                break;
            end
        end
    endtask
    task automatic rd_reg(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                rd = s_axi_rdata;
                rr = s_axi_rresp;
                break;
            end
        end
    endtask
    task automatic rc(input string n, input logic [7:0] a,
                      input logic [31:0] e);
        rd_reg(a);
        check(n, rd, e);
    endtask
    task automatic hit(input logic [2:0] dfw, input logic [7:0] id,
                       input logic [1:0] ab);
        {cyc_is_dma, cyc_is_fetch, cyc_is_write} <= dfw;
        cyc_space_id <= id;
        {cmp_hit_a, cmp_hit_b} <= ab;
        cyc_valid <= 1'b1;
        @(posedge aclk);
        cyc_valid <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic wait_low();
        while (break_request !== 1'b0)
            @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            give_verdict();
        end
    end
    initial
    begin
        {aresetn, trace_enable, branch_event, branch_is_interrupt} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, cyc_valid, cyc_is_dma} = 4'h0;
        {cyc_is_fetch, cyc_is_write, cmp_hit_a, cmp_hit_b} = 4'h0;
        {pc_break_after_a, pc_break_after_b} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, cyc_space_id} = 24'h0;
        {branch_fetch_addr, handler_fetch_addr, s_axi_wdata} = 88'h0;
        {bus_cycle_condition_a, bus_cycle_condition_b} = 12'h0;
        clk_en = 1'b1;
        s_axi_wstrb = 4'hF;
        ack_delay = 8'hFF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_reg(UBTR_OFF_TRACE);
        check("trace valid", 32'(rd[31]), 32'h0);
        wr(UBTR_OFF_ID_A, 32'h5A, UBTR_RESP_OKAY);
        wr(UBTR_OFF_ID_B, 32'hA5, UBTR_RESP_OKAY);
        rc("id a", UBTR_OFF_ID_A, 32'h5A);
        rc("id b", UBTR_OFF_ID_B, 32'hA5);
        wr(8'h14, 32'h1, UBTR_RESP_SLVERR);
        rc("unmapped", 8'h14, 32'h0);
        check("slverr", 32'(rr), 32'(UBTR_RESP_SLVERR));
        branch_event <= 1'b1;
        @(posedge aclk);
        branch_event <= 1'b0;
        trace_enable <= 1'b1;
        rd_reg(UBTR_OFF_TRACE);
        check("trace off", 32'(rd[31]), 32'h0);
        for (int k = 1; k <= 9; k++)
        begin
            branch_event <= 1'b1;
            branch_is_interrupt <= (k == 5);
            branch_fetch_addr <= 28'hABC0000 + 28'(k);
            handler_fetch_addr <= 28'h5550000 + 28'(k);
            @(posedge aclk);
        end
        branch_event <= 1'b0;
        branch_is_interrupt <= 1'b0;
        wr(UBTR_OFF_TRACE, 32'hFFFFFFFF, UBTR_RESP_OKAY);
        for (int k = 9; k >= 2; k--)
        begin
            ex = {4'h8, (k == 5 ? 28'h5550000 : 28'hABC0000) + 28'(k)};
            rc("entry", UBTR_OFF_TRACE, ex);
        end
        rd_reg(UBTR_OFF_TRACE);
        check("empty", 32'(rd[31]), 32'h0);
        branch_event <= 1'b1;
        @(posedge aclk);
        branch_event <= 1'b0;
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_reg(UBTR_OFF_TRACE);
        check("reset", 32'(rd[31]), 32'h0);
        rc("kept a", UBTR_OFF_ID_A, 32'h5A);
        bus_cycle_condition_a <= 6'h3C;
        hit(3'b000, 8'h5A, 2'b10);
        bus_cycle_condition_a <= 6'h15;
        bus_cycle_condition_b <= 6'h2A;
        hit(3'b000, 8'h00, 2'b10);
        rc("no break", UBTR_OFF_STATUS, 32'h0);
        hit(3'b000, 8'h5A, 2'b10);
        check("data", 32'(break_type), 32'(UBTR_BRK_DATA));
        hit(3'b111, 8'hA5, 2'b01);
        rc("status", UBTR_OFF_STATUS, 32'h7);
        rc("flags", UBTR_OFF_FLAGS, 32'h9);
        ack_delay <= 8'h02;
        wait_low();
        rc("kept", UBTR_OFF_FLAGS, 32'h9);
        wr(UBTR_OFF_FLAGS, 32'h8, UBTR_RESP_OKAY);
        rc("clear", UBTR_OFF_FLAGS, 32'h8);
        bus_cycle_condition_a <= 6'h19;
        for (int i = 0; i < 2; i++)
        begin
            pc_break_after_a <= i[0];
            hit(3'b010, 8'h5A, 2'b10);
            check("fetch", 32'(break_type), 32'(i + 1));
            wait_low();
        end
        give_verdict();
    end
endmodule

bind ubtr_top ubtr_chk chk (.aclk, .aresetn, .clk_en, .cyc_valid,
    .cyc_is_fetch, .bus_cycle_condition_a, .bus_cycle_condition_b,
    .break_ack, .break_request, .break_type, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata);
